/* src/mms_pkg.sv */
// Purpose: Shared constants for the measurement sequencer
// Assumes: 125 MHz mclk, APB with 32-bit data
// Notes: Times are kept in their own units; cycle counts derive from them
package mms_pkg;
    localparam int MCLK_HZ = 125_000_000;
    localparam int LINE_HZ_DEF = 60;
    localparam int TENTH_HZ = 600;      // Fixed 1/600 s for low resolution
    localparam int TEST_MS = 5000;      // Segment test display time
    localparam int MSG_MS = 1000;       // Result message display time
    localparam int AVG_N = 10;          // Input conversions averaged per high-res reading
    localparam int DATA_W = 24;

    // Resolution codes
    localparam logic [1:0] RES_LOW = 2'h0;
    localparam logic [1:0] RES_MID = 2'h1;
    localparam logic [1:0] RES_HIGH = 2'h2;
    localparam logic [1:0] RES_RST = RES_MID;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0c;
    localparam logic [7:0] OFS_CAL_VAL = 8'h10;
    localparam logic [7:0] OFS_CAL_CMD = 8'h14;
    localparam logic [7:0] OFS_READING = 8'h18;
    localparam logic [7:0] OFS_OFFSET = 8'h1c;
    localparam logic [7:0] OFS_CAL_CONST = 8'h20;

    // Field positions
    localparam int CTRL_RUN = 0;
    localparam int STAT_RES = 0;        // Bits 1:0
    localparam int STAT_AUTOZERO_OFF_INDICATOR = 2;
    localparam int STAT_BUSY = 3;
    localparam int STAT_PASS = 4;
    localparam int STAT_ERR = 8;        // Bits 11:8
    localparam int STAT_CAL_SW = 12;
    localparam int CAL_START = 0;

    // Interrupt bits
    localparam int INT_W = 4;
    localparam int INT_RDY = 0;
    localparam int INT_TEST = 1;
    localparam int INT_CAL = 2;
    localparam int INT_CAL_REF = 3;

    localparam logic CTRL_RUN_RST = 1'b1;
endpackage

/* src/mms_conv.sv */
// Purpose: Integration timer and converter handshake
// Assumes: adc_valid arrives after integrate falls
// Notes: One conversion per start pulse
`timescale 1ns/1ps
module mms_conv import mms_pkg::*; #(
    parameter int W = DATA_W,
    parameter int PLC_CYC = 2083333,
    parameter int TENTH_CYC = 208333
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic tenth,
    // Converter
    output logic integrate,
    input wire logic adc_valid,
    input wire logic [W-1:0] adc_data,
    // Result
    output logic done,
    output logic [W-1:0] data
);
    logic [31:0] cnt_r;
    logic wait_r;

    // Integration window, then wait for converter result
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            integrate <= 1'b0;
            wait_r <= 1'b0;
            cnt_r <= '0;
        end else if (start) begin
            integrate <= 1'b1;
            wait_r <= 1'b0;
            cnt_r <= tenth ? 32'(TENTH_CYC - 1) : 32'(PLC_CYC - 1);
        end else if (integrate) begin
            if (cnt_r == '0) begin
                integrate <= 1'b0;
                wait_r <= 1'b1;
            end
            cnt_r <= cnt_r - 32'h1;
        end else if (wait_r && adc_valid) begin
            wait_r <= 1'b0;
        end
    end

    // Result capture; stray converter strobes are ignored
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
            data <= '0;
        end else begin
            done <= wait_r && adc_valid && !start;
            if (wait_r && adc_valid) begin
                data <= adc_data;
            end
        end
    end
endmodule

/* src/mms_top.sv */
// Purpose: Measurement sequencer: resolution, autozero, self-test, cal
// Assumes: Key inputs are one-cycle pulses synchronous to mclk
// Notes: Registers on APB; one level interrupt
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module mms_top import mms_pkg::*; #(
    parameter int W = DATA_W,
    parameter int LINE_HZ = LINE_HZ_DEF,
    parameter int PLC_CYC = MCLK_HZ / LINE_HZ,
    parameter int TENTH_CYC = MCLK_HZ / TENTH_HZ,
    parameter int TEST_CYC = (MCLK_HZ / 1000) * TEST_MS,
    parameter int MSG_CYC = (MCLK_HZ / 1000) * MSG_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Front panel keys
    input wire logic shift_key,
    input wire logic range_mode_key,
    input wire logic up_range_key,
    input wire logic down_range_key,
    input wire logic internal_trigger_key,
    input wire logic single_trigger_key,
    input wire logic single_trigger_held,
    // Range and function change events, cal switch
    input wire logic range_change,
    input wire logic function_change,
    input wire logic cal_switch,
    // Self-test fault flags: cal mem, work mem, prog mem, converter
    input wire logic [3:0] test_fail,
    // Converter and input switching
    output logic integrate,
    input wire logic adc_valid,
    input wire logic [W-1:0] adc_data,
    output logic input_short,
    // Display and result
    output logic autozero_off_indicator,
    output logic disp_all_on,
    output logic disp_pass,
    output logic disp_error,
    output logic [3:0] err_code,
    output logic [W-1:0] reading,
    output logic reading_done,
    output logic irq
);
    typedef enum logic [2:0] {
        ST_TEST = 3'h0,
        ST_MSG = 3'h1,
        ST_IDLE = 3'h2,
        ST_ZERO = 3'h3,
        ST_INPUT = 3'h4
    } mms_state_t;

    mms_state_t state_r;
    logic [31:0] tmr_r;
    logic [1:0] res_r;
    logic autozero_off_indicator_r, stale_r, shift_r, test_req_r, pwr_init_r;
    logic run_r, cal_req_r, conv_go_r;
    logic [3:0] avg_cnt_r;
    logic [W+3:0] acc_r;
    logic [W-1:0] offset_r, cal_val_r, cal_const_r;
    logic [INT_W-1:0] int_stat_r, int_mask_r, int_set;
    logic cv_done;
    logic [W-1:0] cv_data, corr, raw;
    logic [W+3:0] sum;
    logic wr, rd_setup, cal_wr, other_key;

    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign cal_wr = wr && paddr == OFS_CAL_CMD && pwdata[CAL_START];
    assign other_key = range_mode_key || up_range_key || down_range_key
        || internal_trigger_key || single_trigger_key;
    assign corr = cv_data - offset_r;
    assign sum = acc_r + {{4{corr[W-1]}}, corr};
    // Ten-sample mean; constant divider traded for simple control
    assign raw = (res_r == RES_HIGH) ? W'(sum / (W+4)'(AVG_N)) : corr;

    mms_conv #(
        .W(W),
        .PLC_CYC(PLC_CYC),
        .TENTH_CYC(TENTH_CYC)
    ) u_conv (
        .mclk(mclk),
        .nrst(nrst),
        .start(conv_go_r),
        .tenth(res_r == RES_LOW),
        .integrate(integrate),
        .adc_valid(adc_valid),
        .adc_data(adc_data),
        .done(cv_done),
        .data(cv_data)
    );

    // Shift arming: any lower-row key consumes it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shift_r <= 1'b0;
        end else if (shift_key) begin
            shift_r <= 1'b1;
        end else if (other_key) begin
            shift_r <= 1'b0;
        end
    end

    // Resolution and autozero mode, reset by power-up state entry
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            res_r <= RES_RST;
            autozero_off_indicator_r <= 1'b0;
        end else if (pwr_init_r) begin
            res_r <= RES_RST;
            autozero_off_indicator_r <= 1'b0;
        end else if (shift_r && state_r != ST_TEST && state_r != ST_MSG) begin
            if (range_mode_key) begin
                res_r <= RES_HIGH;
            end else if (up_range_key) begin
                res_r <= RES_MID;
            end else if (down_range_key) begin
                res_r <= RES_LOW;
            end
            if (internal_trigger_key) begin
                autozero_off_indicator_r <= !autozero_off_indicator_r;
            end
        end
    end

    // Indicator follows the mode flop one cycle later
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            autozero_off_indicator <= 1'b0;
        end else begin
            autozero_off_indicator <= autozero_off_indicator_r;
        end
    end

    // Offset staleness; a renewal request beats the clear by the sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stale_r <= 1'b1;
        end else if (pwr_init_r) begin
            stale_r <= 1'b1;
        end else if (shift_r && internal_trigger_key && !autozero_off_indicator_r) begin
            stale_r <= 1'b1;
        end else if (autozero_off_indicator_r && (range_change || function_change
            || (shift_r && (range_mode_key || up_range_key
            || down_range_key)) || cal_wr)) begin
            stale_r <= 1'b1;
        end else if (state_r == ST_ZERO && cv_done) begin
            stale_r <= 1'b0;
        end
    end

    // Self-test request via shift plus single trigger
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            test_req_r <= 1'b0;
        end else if (shift_r && single_trigger_key) begin
            test_req_r <= 1'b1;
        end else if (state_r == ST_TEST) begin
            test_req_r <= 1'b0;
        end
    end

    // Calibration request, gated by the rear enable switch
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cal_req_r <= 1'b0;
        end else if (cal_wr && cal_switch) begin
            cal_req_r <= 1'b1;
        end else if (state_r == ST_INPUT && cv_done && cal_req_r
            && (res_r != RES_HIGH || avg_cnt_r == 4'(AVG_N - 1))) begin
            cal_req_r <= 1'b0;
        end
    end

    // Main sequencer: self-test, message, offset and input conversions
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_TEST;
            tmr_r <= 32'(TEST_CYC - 1);
            conv_go_r <= 1'b0;
            pwr_init_r <= 1'b0;
            input_short <= 1'b0;
            disp_all_on <= 1'b1;
            disp_pass <= 1'b0;
            disp_error <= 1'b0;
            err_code <= 4'h0;
            avg_cnt_r <= 4'h0;
            acc_r <= '0;
            offset_r <= '0;
            cal_const_r <= '0;
            reading <= '0;
            reading_done <= 1'b0;
        end else begin
            conv_go_r <= 1'b0;
            pwr_init_r <= 1'b0;
            reading_done <= 1'b0;
            unique case (state_r)
                ST_TEST: begin
                    disp_all_on <= 1'b1;
                    if (tmr_r == '0) begin
                        disp_all_on <= 1'b0;
                        err_code <= test_fail;
                        disp_pass <= test_fail == 4'h0;
                        disp_error <= test_fail != 4'h0;
                        tmr_r <= 32'(MSG_CYC - 1);
                        state_r <= ST_MSG;
                    end else begin
                        tmr_r <= tmr_r - 32'h1;
                    end
                end
                ST_MSG: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 32'h1;
                    end else if (!single_trigger_held) begin
                        disp_pass <= 1'b0;
                        disp_error <= 1'b0;
                        pwr_init_r <= 1'b1;
                        offset_r <= '0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    avg_cnt_r <= 4'h0;
                    acc_r <= '0;
                    if (test_req_r) begin
                        tmr_r <= 32'(TEST_CYC - 1);
                        input_short <= 1'b0;
                        state_r <= ST_TEST;
                    end else if (run_r && !pwr_init_r) begin
                        conv_go_r <= 1'b1;
                        if (!autozero_off_indicator_r || stale_r) begin
                            input_short <= 1'b1;
                            state_r <= ST_ZERO;
                        end else begin
                            state_r <= ST_INPUT;
                        end
                    end
                end
                ST_ZERO: begin
                    if (cv_done) begin
                        offset_r <= cv_data;
                        input_short <= 1'b0;
                        conv_go_r <= 1'b1;
                        state_r <= ST_INPUT;
                    end
                end
                ST_INPUT: begin
                    if (cv_done) begin
                        acc_r <= sum;
                        avg_cnt_r <= avg_cnt_r + 4'h1;
                        if (res_r == RES_HIGH
                            && avg_cnt_r != 4'(AVG_N - 1)) begin
                            conv_go_r <= 1'b1;
                        end else begin
                            if (cal_req_r) begin
                                cal_const_r <= cal_val_r - raw;
                                reading <= cal_val_r;
                            end else begin
                                reading <= raw + cal_const_r;
                            end
                            reading_done <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Event sources for the sticky status
    assign int_set[INT_RDY] = reading_done;
    assign int_set[INT_TEST] = pwr_init_r;
    assign int_set[INT_CAL] = state_r == ST_INPUT && cv_done && cal_req_r
        && (res_r != RES_HIGH || avg_cnt_r == 4'(AVG_N - 1));
    assign int_set[INT_CAL_REF] = cal_wr && !cal_switch;

    // Sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_stat_r <= '0;
        end else if (wr && paddr == OFS_INT_STAT) begin
            int_stat_r <= (int_stat_r & ~pwdata[INT_W-1:0]) | int_set;
        end else begin
            int_stat_r <= int_stat_r | int_set;
        end
    end

    // Interrupt level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_r & int_mask_r);
        end
    end

    // Writable registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run_r <= CTRL_RUN_RST;
            int_mask_r <= '0;
            cal_val_r <= '0;
        end else if (wr) begin
            if (paddr == OFS_CTRL) begin
                run_r <= pwdata[CTRL_RUN];
            end
            if (paddr == OFS_INT_MASK) begin
                int_mask_r <= pwdata[INT_W-1:0];
            end
            if (paddr == OFS_CAL_VAL) begin
                cal_val_r <= pwdata[W-1:0];
            end
        end
    end

    // Read data and error latched in setup; zero-wait access phase
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (rd_setup) begin
                pslverr <= 1'b0;
                prdata <= '0;
                unique case (paddr)
                    OFS_CTRL: prdata[CTRL_RUN] <= run_r;
                    OFS_STAT: begin
                        prdata[STAT_RES+1:STAT_RES] <= res_r;
                        prdata[STAT_AUTOZERO_OFF_INDICATOR] <= autozero_off_indicator_r;
                        prdata[STAT_BUSY] <= state_r != ST_IDLE;
                        prdata[STAT_PASS] <= err_code == 4'h0;
                        prdata[STAT_ERR+3:STAT_ERR] <= err_code;
                        prdata[STAT_CAL_SW] <= cal_switch;
                    end
                    OFS_INT_STAT: prdata[INT_W-1:0] <= int_stat_r;
                    OFS_INT_MASK: prdata[INT_W-1:0] <= int_mask_r;
                    OFS_CAL_VAL: prdata[W-1:0] <= cal_val_r;
                    OFS_CAL_CMD: prdata[CAL_START] <= cal_req_r;
                    OFS_READING: prdata[W-1:0] <= reading;
                    OFS_OFFSET: prdata[W-1:0] <= offset_r;
                    OFS_CAL_CONST: prdata[W-1:0] <= cal_const_r;
                    default: pslverr <= 1'b1; // Unmapped address
                endcase
            end
        end
    end
endmodule

/* dv/mms_chk.sv */
// Purpose: Port-level timing checks on the measurement sequencer
// Assumes: Bench shortens the long counts through the top's parameters
// Notes: Window lengths allow one cycle of slack for the edge counting
`timescale 1ns/1ps
module mms_chk import mms_pkg::*; #(
    parameter int PLC_CYC = 30,
    parameter int TENTH_CYC = 5,
    parameter int TEST_CYC = 40,
    parameter int MSG_CYC = 20
) (
    // Clock, reset and bus
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer outputs and the key hold level
    input wire logic single_trigger_held,
    input wire logic integrate,
    input wire logic input_short,
    input wire logic disp_all_on,
    input wire logic disp_pass,
    input wire logic disp_error,
    input wire logic [3:0] err_code,
    input wire logic reading_done
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    int int_cnt_r, test_cnt_r, msg_cnt_r;
    logic msg_on;
    assign msg_on = disp_pass | disp_error;
    // Window counters; a hold on the key restarts the message count
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_cnt_r <= 0;
            test_cnt_r <= 0;
            msg_cnt_r <= 0;
        end else begin
            int_cnt_r <= integrate ? int_cnt_r + 1 : 0;
            test_cnt_r <= disp_all_on ? test_cnt_r + 1 : 0;
            msg_cnt_r <= (msg_on && !single_trigger_held) ? msg_cnt_r + 1 : 0;
        end
    end
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_slverr;
        psel && !penable && paddr > OFS_CAL_CONST |=> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no slave error");
    property p_integ;
        $fell(integrate) |-> int_cnt_r inside {[PLC_CYC-1:PLC_CYC+1],
            [TENTH_CYC-1:TENTH_CYC+1]};
    endproperty
    a_integ: assert property (p_integ) else $error("bad window");
    property p_done;
        reading_done |=> !reading_done;
    endproperty
    a_done: assert property (p_done) else $error("done not a pulse");
    // The short is applied with the start request; the window opens next
    property p_short;
        $rose(input_short) |=> $rose(integrate);
    endproperty
    a_short: assert property (p_short) else $error("short off conv");
    property p_test;
        $fell(disp_all_on) |-> test_cnt_r inside {[TEST_CYC-1:TEST_CYC+1]};
    endproperty
    a_test: assert property (p_test) else $error("test length");
    property p_msg;
        msg_cnt_r <= MSG_CYC + 1;
    endproperty
    a_msg: assert property (p_msg) else $error("message too long");
    property p_hold;
        single_trigger_held && msg_on |=> msg_on;
    endproperty
    a_hold: assert property (p_hold) else $error("message dropped");
    property p_err;
        disp_pass |-> err_code == 4'h0 && !disp_error;
    endproperty
    a_err: assert property (p_err) else $error("pass with error");
endmodule
bind mms_top mms_chk #(.PLC_CYC(PLC_CYC), .TENTH_CYC(TENTH_CYC),
    .TEST_CYC(TEST_CYC), .MSG_CYC(MSG_CYC)) i_chk (.mclk(mclk),
    .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr),
    .single_trigger_held(single_trigger_held), .integrate(integrate),
    .input_short(input_short), .disp_all_on(disp_all_on),
    .disp_pass(disp_pass), .disp_error(disp_error), .err_code(err_code),
    .reading_done(reading_done));

/* dv/mms_adc_model.sv */
// Purpose: Behavioural integrating converter facing the sequencer
// Assumes: Result offered three cycles after the window closes
// Notes: Data line toggles when no result is offered
`timescale 1ns/1ps
module mms_adc_model import mms_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Window and input switching from the sequencer
    input wire logic integrate,
    input wire logic input_short,
    // Values the bench puts at the grounded and live input
    input wire logic [DATA_W-1:0] offset_val,
    input wire logic [DATA_W-1:0] input_val,
    // Result
    output logic adc_valid,
    output logic [DATA_W-1:0] adc_data
);
    logic integ_q, zero_q;
    logic [1:0] wait_q;
    // Grounded input gives the offset; idle data is never the last value
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            integ_q <= 1'b0;
            zero_q <= 1'b0;
            wait_q <= 2'h0;
            adc_valid <= 1'b0;
            adc_data <= '0;
        end else begin
            integ_q <= integrate;
            if (integrate) begin
                zero_q <= input_short;
            end
            wait_q <= {wait_q[0], integ_q & ~integrate};
            adc_valid <= wait_q[1];
            adc_data <= wait_q[1] ? (zero_q ? offset_val : input_val)
                : ~adc_data;
        end
    end
endmodule

/* dv/tb_mms_top.sv */
// Purpose: Self-checking bench for the measurement sequencer
// Assumes: Short counts 30, 5, 40 and 20 cycles
// Notes: Conversions per reading are counted at the converter link
`timescale 1ns/1ps
module tb_mms_top import mms_pkg::*; ();
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, shift_key;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] keys;
    logic held, rng_chg, cal_switch, integrate, adc_valid, input_short;
    logic az_ind, all_on, d_pass, d_err, reading_done, irq, e, fn_chg;
    logic [3:0] test_fail, err_code;
    logic [23:0] adc_data, reading, ofs_v, in_v;
    int bad_count, comparisons, n_cur, n_last;
    mms_top #(.PLC_CYC(30), .TENTH_CYC(5), .TEST_CYC(40), .MSG_CYC(20))
    i_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .shift_key(shift_key),
        .range_mode_key(keys[0]), .up_range_key(keys[1]),
        .down_range_key(keys[2]), .internal_trigger_key(keys[3]),
        .single_trigger_key(keys[4]), .single_trigger_held(held),
        .range_change(rng_chg), .function_change(fn_chg),
        .cal_switch(cal_switch), .test_fail(test_fail),
        .integrate(integrate), .adc_valid(adc_valid), .adc_data(adc_data),
        .input_short(input_short), .autozero_off_indicator(az_ind),
        .disp_all_on(all_on), .disp_pass(d_pass), .disp_error(d_err),
        .err_code(err_code), .reading(reading),
        .reading_done(reading_done), .irq(irq));
    mms_adc_model i_adc (.mclk(mclk), .nrst(nrst), .integrate(integrate),
        .input_short(input_short), .offset_val(ofs_v), .input_val(in_v),
        .adc_valid(adc_valid), .adc_data(adc_data));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Results per reading; done trails the last result by two cycles
    always @(posedge mclk) begin
        if (reading_done === 1'b1) begin
            n_last <= n_cur;
            n_cur <= 0;
        end else if (adc_valid === 1'b1) begin
            n_cur <= n_cur + 1;
        end
    end
    task check(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wrap_up;
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One transfer: setup, then access held until pready at an edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task sh(input int k);
        @(posedge mclk);
        shift_key <= 1'b1;
        @(posedge mclk);
        shift_key <= 1'b0;
        keys[k] <= 1'b1;
        @(posedge mclk);
        keys <= 5'h0;
    endtask
    // 0: reading done, 1: message on, 2: message off
    task wait_ev(input int k);
        int i;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (!(k == 0 ? reading_done === 1'b1 : k == 1 ?
            (d_pass | d_err) === 1'b1 : (d_pass | d_err) === 1'b0)
            && i < 3000);
        check("wait", i < 3000, 1'b1);
    endtask
    // Extra edge lets the tally of the second reading land in n_last
    task two_rd;
        wait_ev(0);
        wait_ev(0);
        @(posedge mclk);
    endtask
    initial begin
        int kk[3], nn[3], i;
        logic [1:0] rr[3];
        kk = '{2, 0, 1};
        nn = '{2, 11, 2};
        rr = '{RES_LOW, RES_HIGH, RES_MID};
        {nrst, psel, penable, pwrite, shift_key, held, rng_chg, fn_chg} = 8'h0;
        {paddr, pwdata, keys, cal_switch, test_fail} = '0;
        ofs_v = 24'h000123;
        in_v = 24'h012345;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        wait_ev(1);
        check("pass", d_pass, 1'b1);
        two_rd();
        check("reading", reading, 24'h012222);
        check("convs", n_last, 2);
        apb(0, OFS_STAT, 0);
        check("stat", rd[2:0], {1'b0, RES_MID});
        for (i = 0; i < 3; i++) begin
            sh(kk[i]);
            two_rd();
            check("reading", reading, 24'h012222);
            check("convs", n_last, nn[i]);
            apb(0, OFS_STAT, 0);
            check("res", rd[1:0], rr[i]);
        end
        // Toggle early in an offset conversion so the renewal point is known
        wait_ev(0);
        sh(3);
        two_rd();
        check("az_ind", az_ind, 1'b1);
        check("convs", n_last, 1);
        ofs_v <= 24'h000200;
        two_rd();
        check("reading", reading, 24'h012222);
        @(posedge mclk);
        rng_chg <= 1'b1;
        @(posedge mclk);
        rng_chg <= 1'b0;
        two_rd();
        check("reading", reading, 24'h012145);
        @(posedge mclk);
        fn_chg <= 1'b1;
        ofs_v <= 24'h000300;
        @(posedge mclk);
        fn_chg <= 1'b0;
        two_rd();
        check("reading", reading, 24'h012045);
        apb(1, OFS_INT_MASK, 0);
        apb(1, OFS_INT_STAT, 32'hf);
        wait_ev(0);
        repeat (2) @(posedge mclk);
        check("irq", irq, 1'b0);
        apb(1, OFS_INT_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        check("irq", irq, 1'b1);
        apb(1, OFS_INT_MASK, 0);
        repeat (2) @(posedge mclk);
        check("irq", irq, 1'b0);
        sh(2);
        test_fail <= 4'h5;
        sh(4);
        wait_ev(1);
        check("err", {d_err, err_code}, 5'h15);
        held <= 1'b1;
        repeat (30) @(posedge mclk);
        check("held", d_err, 1'b1);
        held <= 1'b0;
        test_fail <= 4'h0;
        wait_ev(2);
        apb(0, OFS_STAT, 0);
        check("stat", rd[2:0], {1'b0, RES_MID});
        apb(1, OFS_INT_STAT, 32'hf);
        apb(1, OFS_CAL_VAL, 32'h010000);
        apb(1, OFS_CAL_CMD, 32'h1);
        repeat (4) @(posedge mclk);
        apb(0, OFS_INT_STAT, 0);
        check("refused", rd[INT_CAL_REF:INT_CAL], 2'h2);
        cal_switch <= 1'b1;
        apb(1, OFS_CAL_CMD, 32'h1);
        for (i = 0; i < 200 && rd[INT_CAL] !== 1'b1; i++) begin
            apb(0, OFS_INT_STAT, 0);
        end
        check("cal", rd[INT_CAL], 1'b1);
        two_rd();
        check("reading", reading, 24'h010000);
        apb(0, 8'h40, 0);
        check("slverr", e, 1'b1);
        wrap_up();
    end
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
endmodule
